// *** design/hbpes_defs.svh ***
// constants for the high-bandwidth periodic endpoint sequencer
`ifndef HBPES_DEFS_SVH
`define HBPES_DEFS_SVH

// ==========================================================
// max packet size field layout
`define HBPES_MULT_HI 12
`define HBPES_MULT_LO 11
`define HBPES_SIZE_HI 10
`define HBPES_MAX_TX 2'h3

// ==========================================================
// buffering
`define HBPES_BYTE_W 8
`define HBPES_FIFO_DEPTH 8

// ==========================================================
// timing: clock period and host answer timeout, least time rounds up
`define HBPES_CLK_NS 100
`define HBPES_TIMEOUT_NS 1500
`define HBPES_TIMEOUT_CYC ((`HBPES_TIMEOUT_NS + `HBPES_CLK_NS - 1) / `HBPES_CLK_NS)

`endif

// *** design/hbpes_pkg.sv ***
// types and shared decoding for the endpoint sequencer
`include "hbpes_defs.svh"
package hbpes_pkg;

  // ==========================================================
  // data packet identifiers and state encodings
  typedef enum logic [1:0] {
    HBPES_DATA0 = 2'h0,
    HBPES_DATA1 = 2'h1,
    HBPES_DATA2 = 2'h2,
    HBPES_MDATA = 2'h3
  } hbpes_pid_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'h0,
    HS_TOKEN = 3'h1,
    HS_SEND  = 3'h3,
    HS_WAIT  = 3'h2,
    HS_DONE  = 3'h6
  } hbpes_hstate_t;

  typedef enum logic [1:0] {
    DS_IDLE = 2'h0,
    DS_RX   = 2'h1,
    DS_RSP  = 2'h3
  } hbpes_dstate_t;

  // ==========================================================
  // transactions per microframe, reserved code 3 capped at three
  function automatic logic [1:0] hbpes_mult(input logic [12:0] f);
    case (f[`HBPES_MULT_HI:`HBPES_MULT_LO])
      2'h0:    return 2'h1;
      2'h1:    return 2'h2;
      default: return `HBPES_MAX_TX;
    endcase
  endfunction : hbpes_mult

  // transactions needed for b bytes, never above mult
  function automatic logic [1:0] hbpes_ntx(input logic [11:0] b, input logic [10:0] mps, input logic [1:0] mult);
    logic [1:0] n;
    if (b <= {1'b0, mps}) n = 2'h1;
    else if (b <= {mps, 1'b0}) n = 2'h2;
    else n = 2'h3;
    return (n > mult) ? mult : n;
  endfunction : hbpes_ntx

  // payload of segment seg: full size first, remainder last
  function automatic logic [10:0] hbpes_seglen(input logic [11:0] b, input logic [10:0] mps,
                                               input logic [1:0] n, input logic [1:0] seg);
    logic [11:0] rem;
    rem = b - ((seg == 2'h0) ? 12'h0 : (seg == 2'h1) ? {1'b0, mps} : {mps, 1'b0});
    if (seg != n - 2'h1 || rem > {1'b0, mps}) return mps;
    return rem[10:0];
  endfunction : hbpes_seglen

endpackage : hbpes_pkg

// *** design/hbpes_link_if.sv ***
// transaction-level link between host scheduler and endpoint
`timescale 1ns/1ps
`default_nettype none
interface hbpes_link_if;
  logic                   sof;
  logic                   tok_valid;
  logic                   tok_in;
  hbpes_pkg::hbpes_pid_t  hpid;
  logic            [10:0] hlen;
  logic                   d_valid;
  logic             [7:0] d_data;
  logic                   d_ready;
  logic                   rsp_valid;
  logic                   rsp_nak;
  hbpes_pkg::hbpes_pid_t  rsp_pid;
  logic            [10:0] rsp_len;
  logic                   ack;

  modport host (output sof, tok_valid, tok_in, hpid, hlen, d_valid, d_data, ack,
                input d_ready, rsp_valid, rsp_nak, rsp_pid, rsp_len);
  modport dev  (input sof, tok_valid, tok_in, hpid, hlen, d_valid, d_data, ack,
                output d_ready, rsp_valid, rsp_nak, rsp_pid, rsp_len);
endinterface : hbpes_link_if
`default_nettype wire

// *** design/hbpes_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "hbpes_defs.svh"
module hbpes_fifo #(
  parameter int W = `HBPES_BYTE_W,
  parameter int D = `HBPES_FIFO_DEPTH
) (
  input  wire logic         i_clock,
  input  wire logic         i_rstn,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr;
  logic [AW-1:0] rd;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  // ==========================================================
  // handshakes
  assign o_in_ready  = (count != (AW+1)'(D));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // storage carries no reset, only pointers matter
  always_ff @(posedge i_clock) begin
    if (push) mem[wr] <= i_in_data;
  end

  // pointers wrap by compare so depth need not be a power of two
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      wr    <= '0;
      rd    <= '0;
      count <= '0;
    end else begin
      if (push) wr <= (wr == AW'(D - 1)) ? '0 : wr + 1'b1;
      if (pop) rd <= (rd == AW'(D - 1)) ? '0 : rd + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hbpes_fifo
`default_nettype wire

// *** design/hbpes_device.sv ***
// endpoint end: data pid generation, toggles and out sequence check
`timescale 1ns/1ps
`default_nettype none
`include "hbpes_defs.svh"
module hbpes_device (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  hbpes_link_if.dev        link,
  input  wire logic        i_iso,
  input  wire logic [12:0] i_mps_field,
  input  wire logic [11:0] i_in_bytes,
  input  wire logic        i_int_avail,
  output logic       [7:0] o_out_data,
  output logic             o_out_valid,
  input  wire logic        i_out_ready,
  output logic             o_uf_good,
  output logic             o_uf_bad,
  output logic             o_in_toggle,
  output logic             o_out_toggle
);
  import hbpes_pkg::*;

  hbpes_dstate_t state;
  logic [10:0]   mps;
  logic [1:0]    mult;
  logic [10:0]   rx_len;
  logic [10:0]   rx_cnt;
  logic          discard;
  logic [1:0]    iso_idx;
  logic [1:0]    iso_n;
  logic [1:0]    n_now;
  logic [1:0]    mcnt;
  logic          seq_final;
  logic          seq_err;
  logic          seq_any;
  logic          fifo_ready;
  logic          push;
  logic          tok_out;
  logic          tok_in;

  // ==========================================================
  // decode
  assign mps     = i_mps_field[`HBPES_SIZE_HI:0];
  assign mult    = hbpes_mult(i_mps_field);
  assign tok_out = (state == DS_IDLE) & link.tok_valid & ~link.tok_in;
  assign tok_in  = (state == DS_IDLE) & link.tok_valid & link.tok_in;
  // count fixed by the first token of the microframe
  assign n_now   = (iso_idx == 2'h0) ? hbpes_ntx(i_in_bytes, mps, mult) : iso_n;

  // ==========================================================
  // out reception; sof abandons any half-received packet
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state   <= DS_IDLE;
      rx_len  <= '0;
      rx_cnt  <= '0;
      discard <= 1'b0;
    end else if (link.sof) begin
      state <= DS_IDLE;
    end else begin
      case (state)
        DS_IDLE: if (tok_out) begin
          rx_len  <= link.hlen;
          rx_cnt  <= '0;
          // a repeated interrupt packet is drained but not kept
          discard <= ~i_iso & (link.hpid != hbpes_pid_t'({1'b0, o_out_toggle}));
          if (link.hlen != '0) state <= DS_RX;
          else if (!i_iso) state <= DS_RSP;
        end
        DS_RX: if (link.d_valid && link.d_ready) begin
          rx_cnt <= rx_cnt + 11'h1;
          // isochronous data gets no handshake, so nothing to retry on
          if (rx_cnt == rx_len - 11'h1) state <= i_iso ? DS_IDLE : DS_RSP;
        end
        DS_RSP: state <= DS_IDLE;
        default: state <= DS_IDLE;
      endcase
    end
  end

  // back-pressure from the user reaches the host through d_ready
  assign link.d_ready = (state == DS_RX) & (discard | fifo_ready);
  assign push         = (state == DS_RX) & link.d_valid & ~discard;

  // ==========================================================
  // answers to in tokens one cycle after the token, out handshakes one cycle after entering DS_RSP
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_nak   <= 1'b0;
      link.rsp_pid   <= HBPES_DATA0;
      link.rsp_len   <= '0;
      iso_idx        <= 2'h0;
      iso_n          <= 2'h0;
    end else begin
      link.rsp_valid <= 1'b0;
      if (link.sof) begin
        iso_idx <= 2'h0;
      end else if (tok_in) begin
        link.rsp_valid <= 1'b1;
        if (i_iso) begin
          link.rsp_nak <= 1'b0;
          iso_n        <= n_now;
          if (iso_idx != `HBPES_MAX_TX) iso_idx <= iso_idx + 2'h1;
          if (iso_idx < n_now) begin
            link.rsp_pid <= hbpes_pid_t'(n_now - iso_idx - 2'h1);
            link.rsp_len <= hbpes_seglen(i_in_bytes, mps, n_now, iso_idx);
          end else begin
            link.rsp_pid <= HBPES_DATA0;
            link.rsp_len <= '0;
          end
        end else begin
          link.rsp_nak <= ~i_int_avail;
          link.rsp_pid <= hbpes_pid_t'({1'b0, o_in_toggle});
          link.rsp_len <= mps;
        end
      end else if (state == DS_RSP) begin
        link.rsp_valid <= 1'b1;
        link.rsp_nak   <= 1'b0;
        link.rsp_pid   <= hbpes_pid_t'({1'b0, o_out_toggle});
        link.rsp_len   <= rx_len;
      end
    end
  end

  // ==========================================================
  // interrupt toggles: in flips on host ack, out on accepted data
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_in_toggle  <= 1'b0;
      o_out_toggle <= 1'b0;
    end else begin
      if (!i_iso && link.ack) o_in_toggle <= ~o_in_toggle;
      if (state == DS_RSP && !discard) o_out_toggle <= ~o_out_toggle;
    end
  end

  // ==========================================================
  // out pid pattern check; which mdata got lost is not knowable,
  // so a bad pattern condemns the whole microframe
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      mcnt      <= 2'h0;
      seq_final <= 1'b0;
      seq_err   <= 1'b0;
      seq_any   <= 1'b0;
      o_uf_good <= 1'b0;
      o_uf_bad  <= 1'b0;
    end else begin
      o_uf_good <= 1'b0;
      o_uf_bad  <= 1'b0;
      if (link.sof) begin
        o_uf_good <= seq_any & ~seq_err & seq_final;
        o_uf_bad  <= seq_any & (seq_err | ~seq_final);
        mcnt      <= 2'h0;
        seq_final <= 1'b0;
        seq_err   <= 1'b0;
        seq_any   <= 1'b0;
      end else if (tok_out && i_iso) begin
        seq_any <= 1'b1;
        if (link.hpid == HBPES_MDATA) begin
          if (mcnt != `HBPES_MAX_TX) mcnt <= mcnt + 2'h1;
          if (seq_final || mcnt + 2'h1 >= mult) seq_err <= 1'b1;
        end else begin
          seq_final <= 1'b1;
          // data0/1/2 must follow exactly 0/1/2 mdata packets
          if (seq_final || 2'(link.hpid) != mcnt) seq_err <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // received bytes toward the user
  hbpes_fifo #(
    .W (`HBPES_BYTE_W),
    .D (`HBPES_FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rstn      (i_rstn),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (link.d_data),
    .o_out_valid (o_out_valid),
    .i_out_ready (i_out_ready),
    .o_out_data  (o_out_data)
  );
endmodule : hbpes_device
`default_nettype wire

// *** design/hbpes_host.sv ***
// host scheduler end: issues, stops and retries periodic transactions
`timescale 1ns/1ps
`default_nettype none
`include "hbpes_defs.svh"

// ==========================================================
// Overview of operation
// - interrupt nak ends endpoint until next period
// - interrupt timeout retried within microframe if room
// - timeout at maximum defers retry to next period
// - fewer interrupt transactions only for multiple buffers
// - interrupt transactions use data0/data1 toggle
// - short isochronous in payload ends the microframe
// - isochronous out count follows data within limits
// - isochronous transactions are never retried
// - isochronous endpoints sequence data pids
// - in first pid encodes transaction count
// - in payload sizes per transaction count
// - pid sequence restarts every microframe
// - bad isochronous in answer ends the microframe
// - data0 from isochronous in ends the microframe
// - out uses data0, mdata-data1, mdata-mdata-data2
// - bad out pattern marks whole microframe errored
// - size field holds count and payload size
// - one to three transactions per microframe
// - fill early transactions, remainder goes last
module hbpes_host (
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  hbpes_link_if.host            link,
  input  wire logic             i_sof,
  input  wire logic             i_poll,
  input  wire logic             i_iso,
  input  wire logic             i_dir_in,
  input  wire logic      [12:0] i_mps_field,
  input  wire logic      [11:0] i_out_bytes,
  output logic           [11:0] o_in_bytes,
  output logic            [1:0] o_tx_used,
  output logic                  o_retry_due,
  output logic                  o_uf_end,
  output logic                  o_in_stop,
  output hbpes_pkg::hbpes_pid_t o_last_pid
);
  import hbpes_pkg::*;

  hbpes_hstate_t state;
  logic          iso;
  logic          dir_in;
  logic [10:0]   mps;
  logic [1:0]    mult;
  logic [1:0]    n;
  logic [11:0]   bytes;
  logic [1:0]    seg;
  logic [4:0]    timer;
  logic [10:0]   bidx;
  logic          tog_in;
  logic          tog_out;
  logic [10:0]   out_len;
  logic [1:0]    cnt_nx;
  logic          timeout;
  logic          in_ok;
  hbpes_pid_t    out_pid;
  logic [10:0]   mps_in;
  logic [1:0]    mult_in;

  // ==========================================================
  // decode of configuration and current segment
  assign mps_in  = i_mps_field[`HBPES_SIZE_HI:0];
  assign mult_in = hbpes_mult(i_mps_field);
  assign out_len = hbpes_seglen(bytes, mps, n, seg);
  assign cnt_nx  = o_tx_used + 2'h1;
  assign timeout = (timer == 5'(`HBPES_TIMEOUT_CYC - 1));

  // out data pid: toggle for interrupt, position code for isochronous
  always_comb begin
    if (!iso) out_pid = hbpes_pid_t'({1'b0, tog_out});
    else if (n == 2'h1) out_pid = HBPES_DATA0;
    else if (seg != n - 2'h1) out_pid = HBPES_MDATA;
    else if (n == 2'h2) out_pid = HBPES_DATA1;
    else out_pid = HBPES_DATA2;
  end

  // isochronous in answer check: first pid within count, then descending
  always_comb begin
    if (link.rsp_len > mps) in_ok = 1'b0;
    else if (o_tx_used == 2'h0)
      in_ok = (link.rsp_pid != HBPES_MDATA) && (2'(link.rsp_pid) < mult);
    else
      in_ok = (o_last_pid != HBPES_DATA0) && (2'(link.rsp_pid) == 2'(o_last_pid) - 2'h1);
  end

  // ==========================================================
  // scheduler; a new microframe start overrides whatever is running
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state          <= HS_IDLE;
      iso            <= 1'b0;
      dir_in         <= 1'b0;
      mps            <= '0;
      mult           <= 2'h1;
      n              <= 2'h1;
      bytes          <= '0;
      seg            <= 2'h0;
      timer          <= '0;
      bidx           <= '0;
      tog_in         <= 1'b0;
      tog_out        <= 1'b0;
      o_in_bytes     <= '0;
      o_tx_used      <= 2'h0;
      o_retry_due    <= 1'b0;
      o_uf_end       <= 1'b0;
      o_in_stop      <= 1'b0;
      o_last_pid     <= HBPES_DATA0;
      link.sof       <= 1'b0;
      link.tok_valid <= 1'b0;
      link.tok_in    <= 1'b0;
      link.hpid      <= HBPES_DATA0;
      link.hlen      <= '0;
      link.d_valid   <= 1'b0;
      link.d_data    <= 8'h00;
      link.ack       <= 1'b0;
    end else begin
      link.sof       <= 1'b0;
      link.tok_valid <= 1'b0;
      link.ack       <= 1'b0;
      o_uf_end       <= 1'b0;
      o_in_stop      <= 1'b0;
      if (i_sof) begin
        link.sof     <= 1'b1;
        o_tx_used    <= 2'h0;
        seg          <= 2'h0;
        timer        <= '0;
        link.d_valid <= 1'b0;
        iso          <= i_iso;
        dir_in       <= i_dir_in;
        mps          <= mps_in;
        mult         <= mult_in;
        bytes        <= i_out_bytes;
        o_in_bytes   <= '0;
        // in endpoints get the full count; out only what the data needs
        n <= i_dir_in ? mult_in : hbpes_ntx(i_out_bytes, mps_in, mult_in);
        if (i_poll) begin
          o_retry_due <= 1'b0;
          state <= (i_iso && !i_dir_in && i_out_bytes == '0) ? HS_IDLE : HS_TOKEN;
        end else begin
          state <= HS_IDLE;
        end
      end else begin
        case (state)
          HS_TOKEN: begin
            link.tok_valid <= 1'b1;
            link.tok_in    <= dir_in;
            link.hpid      <= dir_in ? HBPES_DATA0 : out_pid;
            link.hlen      <= dir_in ? 11'h0 : out_len;
            timer          <= '0;
            bidx           <= '0;
            if (dir_in) begin
              state <= HS_WAIT;
            end else if (out_len != '0) begin
              state        <= HS_SEND;
              link.d_valid <= 1'b1;
              link.d_data  <= 8'h00;
            end else begin
              state <= HS_WAIT;
            end
          end
          HS_SEND: if (link.d_ready) begin
            if (bidx == link.hlen - 11'h1) begin
              link.d_valid <= 1'b0;
              if (iso) begin
                // isochronous out moves on without any handshake
                o_tx_used <= cnt_nx;
                seg       <= seg + 2'h1;
                state     <= (cnt_nx == n) ? HS_DONE : HS_TOKEN;
              end else begin
                state <= HS_WAIT;
              end
            end else begin
              bidx        <= bidx + 11'h1;
              link.d_data <= bidx[7:0] + 8'h01;
            end
          end
          HS_WAIT: begin
            timer <= timer + 5'h01;
            if (link.rsp_valid) begin
              o_tx_used <= cnt_nx;
              if (!dir_in) begin
                if (link.rsp_nak) begin
                  state <= HS_DONE;
                end else begin
                  tog_out <= ~tog_out;
                  seg     <= seg + 2'h1;
                  state   <= (seg + 2'h1 == n || cnt_nx == mult) ? HS_DONE : HS_TOKEN;
                end
              end else if (!iso) begin
                if (link.rsp_nak) begin
                  state <= HS_DONE;
                end else begin
                  // ack always; a stale toggle means a repeat, not kept
                  link.ack <= 1'b1;
                  if (2'(link.rsp_pid) == {1'b0, tog_in}) begin
                    tog_in     <= ~tog_in;
                    o_in_bytes <= o_in_bytes + {1'b0, link.rsp_len};
                  end
                  state <= (cnt_nx == mult) ? HS_DONE : HS_TOKEN;
                end
              end else begin
                o_last_pid <= link.rsp_pid;
                if (!in_ok) begin
                  o_in_stop <= 1'b1;
                  state     <= HS_DONE;
                end else begin
                  o_in_bytes <= o_in_bytes + {1'b0, link.rsp_len};
                  if (link.rsp_pid == HBPES_DATA0) state <= HS_DONE;
                  else if (link.rsp_len < mps) state <= HS_DONE;
                  else if (cnt_nx == mult) state <= HS_DONE;
                  else state <= HS_TOKEN;
                end
              end
            end else if (timeout) begin
              o_tx_used <= cnt_nx;
              if (iso) begin
                o_in_stop <= dir_in;
                state     <= HS_DONE;
              end else if (cnt_nx < mult) begin
                // immediate retry keeps latency low; toggle is unchanged
                state <= HS_TOKEN;
              end else begin
                o_retry_due <= 1'b1;
                state       <= HS_DONE;
              end
            end
          end
          HS_DONE: begin
            o_uf_end <= 1'b1;
            state    <= HS_IDLE;
          end
          HS_IDLE: state <= HS_IDLE;
          default: state <= HS_IDLE;
        endcase
      end
    end
  end
endmodule : hbpes_host
`default_nettype wire

// *** test/hbpes_checker.sv ***
// protocol assertions on the link between host and endpoint ends
`timescale 1ns/1ps
`default_nettype none
module hbpes_checker (
  input wire logic                  i_clock,
  input wire logic                  i_rstn,
  input wire logic                  i_iso,
  input wire logic                  sof,
  input wire logic                  tok_valid,
  input wire logic                  tok_in,
  input wire logic                  d_valid,
  input wire logic            [7:0] d_data,
  input wire logic                  d_ready,
  input wire logic                  rsp_valid,
  input wire logic                  rsp_nak,
  input wire hbpes_pkg::hbpes_pid_t rsp_pid,
  input wire logic                  ack
);
  import hbpes_pkg::*;
  logic last_in;
  // ==========================================================
  // direction of the latest token, so acks are judged on in only
  always_ff @(posedge i_clock) begin
    if (!i_rstn) last_in <= 1'b0;
    else if (tok_valid) last_in <= tok_in;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // answer steps
  sequence s_nak; rsp_valid && rsp_nak; endsequence
  sequence s_iso_last; rsp_valid && i_iso && rsp_pid == HBPES_DATA0; endsequence
  sequence s_int_data; rsp_valid && !rsp_nak && !i_iso && last_in; endsequence
  a_nak_quiet: assert property (s_nak |=> (!tok_valid)[*4])
    else $error("token after nak");
  a_data0_ends: assert property (s_iso_last |=> (!tok_valid)[*4])
    else $error("token after last data pid");
  a_iso_no_nak: assert property (i_iso && rsp_valid |-> !rsp_nak)
    else $error("isochronous nak");
  a_iso_out_mute: assert property (i_iso && tok_valid && !tok_in |=> (!rsp_valid)[*3])
    else $error("isochronous out answered");
  a_in_answered: assert property (tok_valid && tok_in |=> rsp_valid)
    else $error("in token unanswered");
  a_int_ack: assert property (s_int_data |=> ack)
    else $error("interrupt data not acked");
  a_ack_cause: assert property (ack |-> $past(rsp_valid) && !$past(rsp_nak))
    else $error("ack without data");
  a_data_hold: assert property (d_valid && !d_ready |=> d_valid && $stable(d_data))
    else $error("out byte dropped while refused");
  a_sof_alone: assert property (sof |-> !tok_valid && !rsp_valid)
    else $error("traffic on microframe start");
endmodule : hbpes_checker
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench joining host and endpoint ends
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hbpes_pkg::*;
  logic        clk, rstn, sof_r, stall, uf_end, good, bad, in_tog, ov, rdue, otog;
  logic [28:0] cfg;
  logic [11:0] in_bytes;
  logic  [1:0] tx_used;
  hbpes_pid_t  last_pid;
  hbpes_pid_t  rp[4], op[4];
  logic [10:0] rl[4], ol[4];
  int          rn, on, ob, rf, gn, bn, err_total, checks;
  hbpes_link_if lk ();
  // cfg packs iso, dir_in, poll, avail, size field and byte count
  hbpes_host u_hbpes_host (.i_clock(clk), .i_rstn(rstn), .link(lk.host), .i_sof(sof_r), .i_poll(cfg[26]),
    .i_iso(cfg[28]), .i_dir_in(cfg[27]), .i_mps_field(cfg[24:12]), .i_out_bytes(cfg[11:0]),
    .o_in_bytes(in_bytes), .o_tx_used(tx_used), .o_retry_due(rdue), .o_uf_end(uf_end), .o_in_stop(),
    .o_last_pid(last_pid));
  hbpes_device u_hbpes_device (.i_clock(clk), .i_rstn(rstn), .link(lk.dev), .i_iso(cfg[28]),
    .i_mps_field(cfg[24:12]), .i_in_bytes(cfg[11:0]), .i_int_avail(cfg[25]), .o_out_data(), .o_out_valid(ov),
    .i_out_ready(!stall), .o_uf_good(good), .o_uf_bad(bad), .o_in_toggle(in_tog), .o_out_toggle(otog));
  hbpes_checker u_hbpes_checker (.i_clock(clk), .i_rstn(rstn), .i_iso(cfg[28]), .sof(lk.sof),
    .tok_valid(lk.tok_valid), .tok_in(lk.tok_in), .d_valid(lk.d_valid), .d_data(lk.d_data),
    .d_ready(lk.d_ready), .rsp_valid(lk.rsp_valid), .rsp_nak(lk.rsp_nak), .rsp_pid(lk.rsp_pid), .ack(lk.ack));
  // ==========================================================
  // transaction log, sampled before the edge's updates land
  always @(posedge clk) begin
    if (lk.rsp_valid) begin
      rp[rn] = lk.rsp_pid;
      rl[rn] = lk.rsp_len;
      rn++;
    end
    if (lk.tok_valid && !lk.tok_in) begin
      op[on] = lk.hpid;
      ol[on] = lk.hlen;
      on++;
    end
    // the token cycle of an out transaction with data shows d_valid before the endpoint is receiving
    rf += int'(lk.d_valid && !lk.d_ready && !lk.tok_valid);
    ob += int'(ov && !stall);
    gn += int'(good);
    bn += int'(bad);
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one microframe: a start pulse, then bounded wait for the end
  task automatic run_uf(input logic iso, din, poll, av, input logic [12:0] mps, input logic [11:0] nb);
    @(posedge clk);
    cfg <= {iso, din, poll, av, mps, nb};
    sof_r <= 1'b1;
    rn = 0;
    on = 0;
    @(posedge clk);
    sof_r <= 1'b0;
    for (int i = 0; i < 300 && uf_end !== 1'b1; i++) @(negedge clk);
    chk(12'(poll && uf_end !== 1'b1), 12'h0);
    repeat (6) @(posedge clk);
  endtask : run_uf
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // scenarios
  task automatic t_int();
    run_uf(1'b0, 1'b1, 1'b1, 1'b1, 13'h0808, 12'h0);
    chk(12'(rn), 12'h2);
    chk(rp[0], 12'h0);
    chk(rp[1], 12'h1);
    chk(in_tog, 12'h0);
    run_uf(1'b0, 1'b1, 1'b1, 1'b0, 13'h0808, 12'h0);
    chk(12'(rn), 12'h1);
    chk(tx_used, 12'h1);
    chk(rdue, 12'h0);
    run_uf(1'b0, 1'b0, 1'b1, 1'b1, 13'h0808, 12'h10);
    chk(12'(on), 12'h2);
    chk(op[1], 12'h1);
    chk(rp[1], 12'h1);
    chk(ol[1], 12'h8);
    chk(otog, 12'h0);
    $display("t_int done");
  endtask : t_int
  task automatic t_iso_in();
    int nbs[3] = '{1000, 1500, 3072};
    int n;
    foreach (nbs[j]) begin
      n = (nbs[j] + 1023) / 1024;
      run_uf(1'b1, 1'b1, 1'b1, 1'b1, 13'h1400, 12'(nbs[j]));
      chk(12'(rn), 12'(n));
      for (int k = 0; k < n; k++) begin
        chk(rp[k], 12'(n - 1 - k));
        chk(rl[k], (k == n - 1) ? 12'(nbs[j] - 1024 * k) : 12'h400);
      end
      chk(in_bytes, 12'(nbs[j]));
      chk(last_pid, 12'h0);
    end
    $display("t_iso_in done");
  endtask : t_iso_in
  task automatic t_iso_out();
    int n;
    for (int nb = 1; nb < 6; nb += 2) begin
      n = (nb + 1) / 2;
      run_uf(1'b1, 1'b0, 1'b1, 1'b1, 13'h1002, 12'(nb));
      chk(12'(on), 12'(n));
      for (int k = 0; k < n; k++) begin
        chk(op[k], (k == n - 1) ? 12'(n - 1) : 12'h3);
        chk(ol[k], (k == n - 1) ? 12'(nb - 2 * k) : 12'h2);
      end
    end
    // consumer stalls so the fifo fills and refuses
    stall <= 1'b1;
    fork
      begin
        repeat (20) @(posedge clk);
        stall <= 1'b0;
      end
    join_none
    run_uf(1'b1, 1'b0, 1'b1, 1'b1, 13'h1004, 12'hc);
    chk(12'(on), 12'h3);
    chk(12'(rf > 0), 12'h1);
    run_uf(1'b1, 1'b0, 1'b0, 1'b1, 13'h1004, 12'hc);
    chk(12'(ob), 12'h25);
    chk(12'(gn), 12'h4);
    chk(12'(bn), 12'h0);
    $display("t_iso_out done");
  endtask : t_iso_out
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog at ten thousand cycles, far beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    sof_r = 1'b0;
    stall = 1'b0;
    cfg = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({tx_used, last_pid, ov, in_tog}, 12'h0);
    t_int();
    t_iso_in();
    t_iso_out();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
